//--- design/tmr2_regs.svh
// Purpose: register map, reset values and fixed counts of the timer block
// Assumes: byte addresses on an 8-bit AXI4-Lite address bus
// Notes:   definitions only
`ifndef TMR2_REGS_SVH
`define TMR2_REGS_SVH

`define TMR2_AW        8
// register byte addresses
`define TMR2_A_CTRL    8'hC8
`define TMR2_A_CNT     8'hD0
`define TMR2_A_RLD     8'hD4
`define TMR2_A_STAT    8'hD8
`define TMR2_A_IEN     8'hDC
`define TMR2_A_ICLR    8'hE0
`define TMR2_A_MODE    8'hE4
`define TMR2_A_BITW    8'hE8
// status, enable and clear share one layout
`define TMR2_F_OVF     0
`define TMR2_F_EXT     1
// reset values
`define TMR2_CTRL_RST  8'h00
`define TMR2_RLD_RST   16'h0000
`define TMR2_IEN_RST   2'h0
// bus answers
`define TMR2_RESP_OK   2'h0
`define TMR2_RESP_ERR  2'h2
// pin synchroniser depth
`define TMR2_SYNC_LEN  3

`endif

//--- design/tmr2_pkg.sv
// Purpose: shared types of the timer block
// Assumes: nothing
// Notes:   control struct order matches the control byte, bit 7 first
package tmr2_pkg;

    typedef struct packed {
        logic ovf;      // overflow_flag
        logic ext;      // external_flag
        logic rclk;     // rx_clock_select
        logic tx_clock_select;     // tx_clock_select
        logic exen;     // ext_trigger_enable
        logic run;      // run_control
        logic cnt_sel;  // counter_select
        logic cap_sel;  // capture_select
    } tmr2_ctl_t;

    typedef enum logic [2:0] {
        W_IDLE = 3'b001,
        W_ACC  = 3'b010,
        W_RESP = 3'b100
    } tmr2_wst_t;

    typedef enum logic [2:0] {
        R_IDLE = 3'b001,
        R_ACC  = 3'b010,
        R_RESP = 3'b100
    } tmr2_rdst_t;

endpackage : tmr2_pkg

//--- design/tmr2_pin_sync.sv
// Purpose: bring an outside pin into ref_clk and flag its falling edges
// Assumes: pin idles high
// Notes:   a change counts once the second and third stages agree
`timescale 1ns/1ps
`include "tmr2_regs.svh"
module tmr2_pin_sync (
    input  wire logic ref_clk,
    input  wire logic rst_n,
    input  wire logic pin_in,
    output logic      fall_pulse
);
    logic [`TMR2_SYNC_LEN-1:0] sh_q, sh_d;
    logic                      lvl_q, lvl_d;
    logic                      fall_q, fall_d;

    // first stage feeds only the second; filter looks at stages 2 and 3
    always_comb begin
        sh_d   = {sh_q[`TMR2_SYNC_LEN-2:0], pin_in};
        lvl_d  = (sh_q[1] == sh_q[2]) ? sh_q[2] : lvl_q;
        fall_d = lvl_q & ~lvl_d;
    end

    // reset to high so release never looks like an edge
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            sh_q   <= '1;
            lvl_q  <= 1'b1;
            fall_q <= 1'b0;
        end else begin
            sh_q   <= sh_d;
            lvl_q  <= lvl_d;
            fall_q <= fall_d;
        end
    end

    assign fall_pulse = fall_q;
endmodule : tmr2_pin_sync

//--- design/tmr2_count16.sv
// Purpose: up counter with parallel load and wrap flag
// Assumes: load has priority over tick
// Notes:   wrap is combinational, true in the cycle the count leaves max
`timescale 1ns/1ps
module tmr2_count16 #(
    parameter int W = 16
) (
    input  wire logic         ref_clk,
    input  wire logic         rst_n,
    input  wire logic         tick,
    input  wire logic         load,
    input  wire logic [W-1:0] load_val,
    output logic      [W-1:0] count,
    output logic              wrap
);
    logic [W-1:0] cnt_q, cnt_d;

    // load beats counting so a reload never loses to a tick
    always_comb begin
        cnt_d = cnt_q;
        if (load) begin
            cnt_d = load_val;
        end else if (tick) begin
            cnt_d = cnt_q + W'(1);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    assign count = cnt_q;
    assign wrap  = tick & (&cnt_q);
endmodule : tmr2_count16

//--- design/tmr2_ctrl.sv
// Purpose: control, status and AXI4-Lite registers of the 16-bit timer
// Assumes: pins asynchronous; serial_mode and t1_overflow on ref_clk
// Notes:   one write and one read may be in flight at a time
//
// How it works
// - overflow sets overflow_flag only while both serial clock selects clear
// - qualified trigger falling edge causing capture or reload sets external_flag
// - external_flag with interrupt enabled raises the timer interrupt
// - in up/down mode external_flag never raises an interrupt
// - rx_clock_select routes this overflow to receive clock, modes 1 and 3
// - tx_clock_select routes this overflow to transmit clock, modes 1 and 3
// - trigger pin events are ignored unless ext_trigger_enable is set
// - trigger edges act only when the timer is not clocking the serial port
// - run_control clear stops counting, set lets it count
// - counter_select picks peripheral clock or count pin falling edges
// - capture_select picks capture or reload; serial use forces auto-reload
// - control byte resets to zero and single bits are writable alone
// - baud and clock generation share the one reload value
`timescale 1ns/1ps
`include "tmr2_regs.svh"
module tmr2_ctrl
    import tmr2_pkg::*;
(
    input  wire logic                ref_clk,
    input  wire logic                rst_n,
    input  wire logic                s_awvalid,
    output logic                     s_awready,
    input  wire logic [`TMR2_AW-1:0] s_awaddr,
    input  wire logic                s_wvalid,
    output logic                     s_wready,
    input  wire logic [31:0]         s_wdata,
    input  wire logic [3:0]          s_wstrb,
    output logic                     s_bvalid,
    input  wire logic                s_bready,
    output logic [1:0]               s_bresp,
    input  wire logic                s_arvalid,
    output logic                     s_arready,
    input  wire logic [`TMR2_AW-1:0] s_araddr,
    output logic                     s_rvalid,
    input  wire logic                s_rready,
    output logic [31:0]              s_rdata,
    output logic [1:0]               s_rresp,
    input  wire logic                count_input_pin,
    input  wire logic                ext_trigger_pin,
    input  wire logic [1:0]          serial_mode,
    input  wire logic                t1_overflow,
    output logic                     rx_baud_tick,
    output logic                     tx_baud_tick,
    output logic                     irq
);
    tmr2_wst_t   w_st_q, w_st_d;
    tmr2_rdst_t  r_st_q, r_st_d;
    tmr2_ctl_t   ctl_q, ctl_d;
    logic [15:0] rld_q, rld_d;
    logic [1:0]  ien_q, ien_d;
    logic        updn_q, updn_d;
    logic [1:0]  bresp_q, bresp_d;
    logic [31:0] rdata_q, rdata_d;
    logic [1:0]  rresp_q, rresp_d;
    logic        rx_q, rx_d, tx_q, tx_d, irq_q, irq_d;
    logic        t2_fall, ext_fall, wrap, tick, trig, capture, reload;
    logic        serial_sel, ovf_set, cnt_wr, cnt_load, wr_go, rd_go;
    logic [15:0] cnt, cnt_wval, cnt_lval;

    // merge a 16-bit register with the two low write lanes
    function automatic logic [15:0] merge16(
        input logic [15:0] old_v,
        input logic [31:0] new_v,
        input logic [3:0]  strb
    );
        logic [15:0] m;
        m = old_v;
        if (strb[0]) m[7:0] = new_v[7:0];
        if (strb[1]) m[15:8] = new_v[15:8];
        return m;
    endfunction : merge16

    tmr2_pin_sync u_cnt_pin (
        .ref_clk    (ref_clk),
        .rst_n      (rst_n),
        .pin_in     (count_input_pin),
        .fall_pulse (t2_fall)
    );

    tmr2_pin_sync u_trg_pin (
        .ref_clk    (ref_clk),
        .rst_n      (rst_n),
        .pin_in     (ext_trigger_pin),
        .fall_pulse (ext_fall)
    );

    tmr2_count16 #(.W(16)) u_cnt (
        .ref_clk  (ref_clk),
        .rst_n    (rst_n),
        .tick     (tick),
        .load     (cnt_load),
        .load_val (cnt_lval),
        .count    (cnt),
        .wrap     (wrap)
    );

    // timer events; serial use masks triggers and forces reload
    assign serial_sel = ctl_q.rclk | ctl_q.tx_clock_select;
    assign tick = ctl_q.run & (ctl_q.cnt_sel ? t2_fall : 1'b1);
    assign trig = ctl_q.exen & ext_fall & ~serial_sel;
    assign capture = trig & ctl_q.cap_sel;
    assign reload = (wrap & (serial_sel | ~ctl_q.cap_sel))
                  | (trig & ~ctl_q.cap_sel);
    assign ovf_set = wrap & ~serial_sel;
    // one reload value serves baud and clock duty alike
    assign cnt_load = cnt_wr | reload;
    assign cnt_lval = cnt_wr ? cnt_wval : rld_q;

    assign wr_go = (w_st_q == W_ACC);
    assign rd_go = (r_st_q == R_ACC);

    // write channel: take address and data together, then answer
    always_comb begin
        w_st_d  = w_st_q;
        bresp_d = bresp_q;
        unique case (w_st_q)
            W_IDLE: begin
                if (s_awvalid && s_wvalid) w_st_d = W_ACC;
            end
            W_ACC: begin
                w_st_d  = W_RESP;
                bresp_d = `TMR2_RESP_OK;
                unique case (s_awaddr)
                    `TMR2_A_CTRL, `TMR2_A_CNT, `TMR2_A_RLD,
                    `TMR2_A_STAT, `TMR2_A_IEN, `TMR2_A_ICLR,
                    `TMR2_A_MODE, `TMR2_A_BITW: ;
                    default: bresp_d = `TMR2_RESP_ERR;
                endcase
            end
            W_RESP: begin
                if (s_bready) w_st_d = W_IDLE;
            end
        endcase
    end

    // register updates; hardware sets land after software clears
    always_comb begin
        ctl_d    = ctl_q;
        rld_d    = rld_q;
        ien_d    = ien_q;
        updn_d   = updn_q;
        cnt_wr   = 1'b0;
        cnt_wval = cnt;
        if (wr_go) begin
            unique case (s_awaddr)
                `TMR2_A_CTRL: begin
                    if (s_wstrb[0]) ctl_d = tmr2_ctl_t'(s_wdata[7:0]);
                end
                `TMR2_A_CNT: begin
                    cnt_wr   = |s_wstrb[1:0];
                    cnt_wval = merge16(cnt, s_wdata, s_wstrb);
                end
                `TMR2_A_RLD: rld_d = merge16(rld_q, s_wdata, s_wstrb);
                `TMR2_A_IEN: begin
                    if (s_wstrb[0]) ien_d = s_wdata[1:0];
                end
                `TMR2_A_ICLR: begin
                    // write one to clear
                    if (s_wstrb[0] && s_wdata[`TMR2_F_OVF]) ctl_d.ovf = 1'b0;
                    if (s_wstrb[0] && s_wdata[`TMR2_F_EXT]) ctl_d.ext = 1'b0;
                end
                `TMR2_A_MODE: begin
                    if (s_wstrb[0]) updn_d = s_wdata[0];
                end
                `TMR2_A_BITW: begin
                    // mask in byte 1 picks which control bits take byte 0
                    if (s_wstrb[0] && s_wstrb[1]) begin
                        ctl_d = tmr2_ctl_t'((ctl_q & ~s_wdata[15:8])
                              | (s_wdata[7:0] & s_wdata[15:8]));
                    end
                end
                default: ;
            endcase
        end
        if (ovf_set) ctl_d.ovf = 1'b1;
        if (trig) ctl_d.ext = 1'b1;
        if (capture) rld_d = cnt;
    end

    // read channel: one cycle of arready, then data held until rready
    always_comb begin
        r_st_d  = r_st_q;
        rdata_d = rdata_q;
        rresp_d = rresp_q;
        unique case (r_st_q)
            R_IDLE: begin
                if (s_arvalid) r_st_d = R_ACC;
            end
            R_ACC: begin
                r_st_d  = R_RESP;
                rdata_d = 32'h0000_0000;
                rresp_d = `TMR2_RESP_OK;
                unique case (s_araddr)
                    `TMR2_A_CTRL: rdata_d[7:0] = ctl_q;
                    `TMR2_A_CNT:  rdata_d[15:0] = cnt;
                    `TMR2_A_RLD:  rdata_d[15:0] = rld_q;
                    `TMR2_A_STAT: rdata_d[1:0] = {ctl_q.ext, ctl_q.ovf};
                    `TMR2_A_IEN:  rdata_d[1:0] = ien_q;
                    `TMR2_A_MODE: rdata_d[0] = updn_q;
                    `TMR2_A_ICLR, `TMR2_A_BITW: ; // write-only, read zero
                    default: rresp_d = `TMR2_RESP_ERR;
                endcase
            end
            R_RESP: begin
                if (s_rready) r_st_d = R_IDLE;
            end
        endcase
    end

    // serial clocks only take this overflow in serial modes 1 and 3
    always_comb begin
        rx_d  = (ctl_q.rclk && serial_mode[0]) ? wrap : t1_overflow;
        tx_d  = (ctl_q.tx_clock_select && serial_mode[0]) ? wrap : t1_overflow;
        irq_d = (ctl_q.ovf & ien_q[`TMR2_F_OVF])
              | (ctl_q.ext & ien_q[`TMR2_F_EXT] & ~updn_q);
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            w_st_q  <= W_IDLE;
            r_st_q  <= R_IDLE;
            ctl_q   <= tmr2_ctl_t'(`TMR2_CTRL_RST);
            rld_q   <= `TMR2_RLD_RST;
            ien_q   <= `TMR2_IEN_RST;
            updn_q  <= 1'b0;
            bresp_q <= `TMR2_RESP_OK;
            rdata_q <= 32'h0000_0000;
            rresp_q <= `TMR2_RESP_OK;
            rx_q    <= 1'b0;
            tx_q    <= 1'b0;
            irq_q   <= 1'b0;
        end else begin
            w_st_q  <= w_st_d;
            r_st_q  <= r_st_d;
            ctl_q   <= ctl_d;
            rld_q   <= rld_d;
            ien_q   <= ien_d;
            updn_q  <= updn_d;
            bresp_q <= bresp_d;
            rdata_q <= rdata_d;
            rresp_q <= rresp_d;
            rx_q    <= rx_d;
            tx_q    <= tx_d;
            irq_q   <= irq_d;
        end
    end

    // one-hot state bits are the handshake flops themselves
    assign s_awready    = w_st_q[1];
    assign s_wready     = w_st_q[1];
    assign s_bvalid     = w_st_q[2];
    assign s_bresp      = bresp_q;
    assign s_arready    = r_st_q[1];
    assign s_rvalid     = r_st_q[2];
    assign s_rdata      = rdata_q;
    assign s_rresp      = rresp_q;
    assign rx_baud_tick = rx_q;
    assign tx_baud_tick = tx_q;
    assign irq          = irq_q;

    // checks on the timer behaviour
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    a_ovf_sets: assert property (ovf_set |=> ctl_q.ovf)
        else $error("overflow did not set overflow_flag");
    a_ovf_cause: assert property ($rose(ctl_q.ovf) |->
        $past(ovf_set) || $past(wr_go))
        else $error("overflow_flag rose without cause");
    a_ext_sets: assert property (trig |=> ctl_q.ext)
        else $error("trigger did not set external_flag");
    a_ext_irq: assert property (ctl_q.ext && ien_q[1] && !updn_q
        |=> irq)
        else $error("external_flag did not raise irq");
    a_updn_quiet: assert property (updn_q && !(ctl_q.ovf && ien_q[0])
        |=> !irq)
        else $error("irq raised by external_flag in up/down mode");
    a_rx_route: assert property (ctl_q.rclk && serial_mode[0]
        |=> rx_baud_tick == $past(wrap))
        else $error("receive clock not from this overflow");
    a_tx_route: assert property (!ctl_q.tx_clock_select
        |=> tx_baud_tick == $past(t1_overflow))
        else $error("transmit clock not from timer 1");
    a_exen_off: assert property (!ctl_q.exen && !ctl_q.ext && !wr_go
        |=> !ctl_q.ext)
        else $error("external_flag set while trigger disabled");
    a_serial_hold: assert property (serial_sel && ext_fall && !wr_go
        |=> rld_q == $past(rld_q))
        else $error("trigger acted while clocking serial port");
    a_run_stop: assert property (!ctl_q.run && !cnt_load
        |=> cnt == $past(cnt))
        else $error("counter moved while stopped");
    a_clk_count: assert property (ctl_q.run && !ctl_q.cnt_sel && !cnt_load
        |=> cnt == $past(cnt) + 16'h0001)
        else $error("counter missed a peripheral clock");
    a_forced_rld: assert property (wrap && serial_sel && !cnt_wr
        |=> cnt == $past(rld_q))
        else $error("no forced reload on overflow");
    a_capture: assert property (capture |=> rld_q == $past(cnt))
        else $error("capture did not copy the counter");
    a_ctl_reset: assert property (@(posedge ref_clk) disable iff (1'b0)
        !rst_n |=> ctl_q == tmr2_ctl_t'(`TMR2_CTRL_RST))
        else $error("control byte not zero after reset");

    c_capture: cover property (capture);
    c_trig_reload: cover property (trig && !ctl_q.cap_sel);
    c_baud_ovf: cover property (wrap && serial_sel);
    c_irq: cover property ($rose(irq));
endmodule : tmr2_ctrl

//--- verif/tmr2_far_model.sv
// Purpose: far side of the timer block: pins, timer 1 and serial port
// Assumes: both pins idle high; timer 1 overflows every T1_DIV cycles
// Notes:   pin edges are made on request through fall_pin
`timescale 1ns/1ps
module tmr2_far_model #(
    parameter int T1_DIV = 10
) (
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    input  wire logic        t1_en,
    input  wire logic        rx_baud_tick,
    input  wire logic        tx_baud_tick,
    output logic             count_input_pin,
    output logic             ext_trigger_pin,
    output logic             t1_overflow,
    output logic [15:0]      rx_cnt,
    output logic [15:0]      tx_cnt
);
    logic [7:0] div_q;

    // timer 1 overflow pulse, one cycle wide
    always_ff @(posedge ref_clk) begin
        if (!rst_n || !t1_en) begin
            div_q       <= 8'h00;
            t1_overflow <= 1'b0;
        end else begin
            t1_overflow <= (div_q == 8'(T1_DIV - 1));
            div_q       <= (div_q == 8'(T1_DIV - 1)) ? 8'h00 : div_q + 8'h01;
        end
    end

    // serial port side counts the baud ticks it is given
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            rx_cnt <= 16'h0000;
            tx_cnt <= 16'h0000;
        end else begin
            rx_cnt <= rx_cnt + {15'h0000, rx_baud_tick};
            tx_cnt <= tx_cnt + {15'h0000, tx_baud_tick};
        end
    end

    initial begin
        count_input_pin = 1'b1;
        ext_trigger_pin = 1'b1;
    end

    // low for 8 cycles so the pin filter sees a clean level
    task automatic fall_pin(input logic trig);
        @(posedge ref_clk);
        if (trig) ext_trigger_pin <= 1'b0;
        else count_input_pin <= 1'b0;
        repeat (8) @(posedge ref_clk);
        ext_trigger_pin <= 1'b1;
        count_input_pin <= 1'b1;
        repeat (8) @(posedge ref_clk);
    endtask : fall_pin
endmodule : tmr2_far_model

//--- verif/tb.sv
// Purpose: self-checking bench for the timer control block
// Assumes: bus answer time is left to the design
// Notes:   each scenario task judges its own results
`timescale 1ns/1ps
`include "tmr2_regs.svh"
module tb;
    logic        ref_clk, rst_n, s_awvalid, s_awready, s_wvalid;
    logic        s_wready, s_bvalid, s_bready, s_arvalid, s_arready;
    logic        s_rvalid, s_rready, cnt_pin, trg_pin, t1_ovf;
    logic        rx_tick, tx_tick, irq, t1_en;
    logic [7:0]  s_awaddr, s_araddr;
    logic [31:0] s_wdata, s_rdata, rdat;
    logic [3:0]  s_wstrb;
    logic [1:0]  s_bresp, s_rresp, serial_mode, bresp, rresp;
    logic [15:0] rx_cnt, tx_cnt;
    int          num_errors, samples_checked;

    tmr2_ctrl tmr2_ctrl_i (
        .ref_clk, .rst_n, .s_awvalid, .s_awready, .s_awaddr, .s_wvalid,
        .s_wready, .s_wdata, .s_wstrb, .s_bvalid, .s_bready, .s_bresp,
        .s_arvalid, .s_arready, .s_araddr, .s_rvalid, .s_rready, .s_rdata,
        .s_rresp, .count_input_pin(cnt_pin), .ext_trigger_pin(trg_pin),
        .serial_mode, .t1_overflow(t1_ovf), .rx_baud_tick(rx_tick),
        .tx_baud_tick(tx_tick), .irq
    );
    tmr2_far_model tmr2_far_model_i (
        .ref_clk, .rst_n, .t1_en, .rx_baud_tick(rx_tick),
        .tx_baud_tick(tx_tick), .count_input_pin(cnt_pin),
        .ext_trigger_pin(trg_pin), .t1_overflow(t1_ovf), .rx_cnt, .tx_cnt
    );

    always #5 ref_clk = ~ref_clk;

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            num_errors++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask : chk

    // aw and w offered together, each dropped at its own handshake
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int   n;
        logic aw, w;
        n = 0;
        aw = 1'b0;
        w = 1'b0;
        s_awvalid <= 1'b1;
        s_wvalid <= 1'b1;
        s_awaddr <= a;
        s_wdata <= d;
        while (!(aw && w) && n < 50) begin
            @(posedge ref_clk);
            n++;
            if (s_awready === 1'b1) begin
                aw = 1'b1;
                s_awvalid <= 1'b0;
            end
            if (s_wready === 1'b1) begin
                w = 1'b1;
                s_wvalid <= 1'b0;
            end
        end
        s_bready <= 1'b1;
        do begin
            @(posedge ref_clk);
            n++;
        end while (s_bvalid !== 1'b1 && n < 50);
        bresp = s_bresp;
        s_bready <= 1'b0;
        @(posedge ref_clk);
        if (n >= 50) chk("bus_wait", 32'h0, 32'h1);
    endtask : wr

    task automatic rd(input logic [7:0] a);
        int n;
        n = 0;
        s_arvalid <= 1'b1;
        s_araddr <= a;
        do begin
            @(posedge ref_clk);
            n++;
        end while (s_arready !== 1'b1 && n < 50);
        s_arvalid <= 1'b0;
        s_rready <= 1'b1;
        do begin
            @(posedge ref_clk);
            n++;
        end while (s_rvalid !== 1'b1 && n < 50);
        rdat = s_rdata;
        rresp = s_rresp;
        s_rready <= 1'b0;
        @(posedge ref_clk);
        if (n >= 50) chk("bus_wait", 32'h0, 32'h1);
    endtask : rd

    task automatic rdc(input logic [7:0] a, input logic [31:0] e,
                       input string nm);
        rd(a);
        chk(nm, e, rdat);
    endtask : rdc

    task automatic trig;
        tmr2_far_model_i.fall_pin(1'b1);
        repeat (6) @(posedge ref_clk);
    endtask : trig

    // baud phase is free, so one tick either way is accepted
    task automatic win(input int rxe, input int txe);
        int r0, t0, dr, dt;
        r0 = int'(rx_cnt);
        t0 = int'(tx_cnt);
        repeat (320) @(posedge ref_clk);
        dr = int'(rx_cnt) - r0;
        dt = int'(tx_cnt) - t0;
        chk("rx_ticks", 32'h1, 32'(dr >= rxe - 1 && dr <= rxe + 1));
        chk("tx_ticks", 32'h1, 32'(dt >= txe - 1 && dt <= txe + 1));
    endtask : win

    task automatic t_reset;
        rdc(`TMR2_A_CTRL, 32'h0, "ctrl_rst");
        rdc(`TMR2_A_RLD, 32'h0, "rld_rst");
        rdc(`TMR2_A_IEN, 32'h0, "ien_rst");
        rd(8'hF0);
        chk("bad_rresp", {30'h0, `TMR2_RESP_ERR}, {30'h0, rresp});
        chk("bad_rdat", 32'h0, rdat);
        wr(8'hF0, 32'hFF);
        chk("bad_bresp", {30'h0, `TMR2_RESP_ERR}, {30'h0, bresp});
    endtask : t_reset

    task automatic t_ovf;
        wr(`TMR2_A_IEN, 32'h1);
        wr(`TMR2_A_CNT, 32'hFFFE);
        wr(`TMR2_A_BITW, 32'h0404);
        repeat (4) @(posedge ref_clk);
        chk("irq_ovf", 32'h1, {31'h0, irq});
        rdc(`TMR2_A_CTRL, 32'h84, "ctrl_ovf");
        rdc(`TMR2_A_STAT, 32'h1, "stat_ovf");
        wr(`TMR2_A_BITW, 32'h0400);
        rdc(`TMR2_A_CTRL, 32'h80, "ctrl_bit");
        wr(`TMR2_A_ICLR, 32'h1);
        rdc(`TMR2_A_STAT, 32'h0, "stat_clr");
        chk("irq_clr", 32'h0, {31'h0, irq});
        wr(`TMR2_A_CNT, 32'h1234);
        repeat (20) @(posedge ref_clk);
        rdc(`TMR2_A_CNT, 32'h1234, "cnt_stop");
        wr(`TMR2_A_IEN, 32'h0);
    endtask : t_ovf

    // count pin edges only; the clock must not add to the count
    task automatic t_pin;
        wr(`TMR2_A_CNT, 32'h0);
        wr(`TMR2_A_CTRL, 32'h06);
        repeat (3) tmr2_far_model_i.fall_pin(1'b0);
        repeat (6) @(posedge ref_clk);
        wr(`TMR2_A_CTRL, 32'h0);
        rdc(`TMR2_A_CNT, 32'h3, "cnt_pin");
    endtask : t_pin

    task automatic t_trig;
        wr(`TMR2_A_CNT, 32'h5A5A);
        wr(`TMR2_A_CTRL, 32'h01);
        trig();
        rdc(`TMR2_A_RLD, 32'h0, "rld_noexen");
        rdc(`TMR2_A_STAT, 32'h0, "ext_noexen");
        wr(`TMR2_A_CTRL, 32'h09);
        trig();
        rdc(`TMR2_A_RLD, 32'h5A5A, "rld_cap");
        rdc(`TMR2_A_STAT, 32'h2, "ext_cap");
        wr(`TMR2_A_RLD, 32'h1111);
        wr(`TMR2_A_CTRL, 32'h08);
        trig();
        rdc(`TMR2_A_CNT, 32'h1111, "cnt_rld");
        rdc(`TMR2_A_STAT, 32'h2, "ext_rld");
    endtask : t_trig

    task automatic t_irq;
        wr(`TMR2_A_IEN, 32'h2);
        repeat (3) @(posedge ref_clk);
        chk("irq_ext", 32'h1, {31'h0, irq});
        wr(`TMR2_A_MODE, 32'h1);
        repeat (3) @(posedge ref_clk);
        chk("irq_updown", 32'h0, {31'h0, irq});
        wr(`TMR2_A_MODE, 32'h0);
        wr(`TMR2_A_ICLR, 32'h2);
        rdc(`TMR2_A_STAT, 32'h0, "ext_clr");
        chk("irq_off", 32'h0, {31'h0, irq});
        wr(`TMR2_A_IEN, 32'h0);
    endtask : t_irq

    // capture bit set but serial use must force reload every 16 ticks
    task automatic t_serial;
        t1_en <= 1'b1;
        serial_mode <= 2'h1;
        wr(`TMR2_A_RLD, 32'hFFF0);
        wr(`TMR2_A_CNT, 32'hFFF0);
        wr(`TMR2_A_CTRL, 32'h1D);
        trig();
        win(32, 20);
        rdc(`TMR2_A_STAT, 32'h0, "stat_serial");
        rdc(`TMR2_A_RLD, 32'hFFF0, "rld_serial");
        serial_mode <= 2'h2;
        win(32, 32);
        serial_mode <= 2'h3;
        wr(`TMR2_A_CTRL, 32'h25);
        win(20, 32);
        wr(`TMR2_A_CTRL, 32'h0);
    endtask : t_serial

    task automatic results;
        if (num_errors == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : results

    initial begin
        ref_clk = 1'b0;
        rst_n = 1'b0;
        {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = 5'h00;
        s_awaddr = 8'h00;
        s_araddr = 8'h00;
        s_wdata = 32'h0;
        s_wstrb = 4'hF;
        serial_mode = 2'h0;
        t1_en = 1'b0;
        num_errors = 0;
        samples_checked = 0;
        repeat (20) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        t_reset();
        t_ovf();
        t_pin();
        t_trig();
        t_irq();
        t_serial();
        results();
    end

    // whole run is under two thousand cycles
    initial begin
        repeat (20000) @(posedge ref_clk);
        chk("watchdog", 32'h0, 32'h1);
        results();
    end
endmodule : tb
